// file: pkg/msc_pkg.sv
package msc_pkg;

    // Clock rate and the one millisecond tick
    localparam int unsigned CLK_NS   = 16'h0005;
    localparam int unsigned TICK_NS  = 32'h000f_4240;
    localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;

    // Unit conversions
    localparam int unsigned MS_S  = 16'h03e8;
    localparam int unsigned S_MIN = 16'h003c;
    localparam int unsigned S_H   = 16'h0e10;

    // Millisecond counters
    localparam int TW = 25;
    typedef logic [TW-1:0] msc_ms_t;

    // Times in their own units
    localparam int unsigned CONC_S   = 16'h0004;
    localparam int unsigned TAIL_S   = 16'h0005;
    localparam int unsigned SEQ_H    = 16'h0008;
    localparam int unsigned STD_MIN  = 16'h000a;
    localparam int unsigned LONG_H   = 16'h0008;
    localparam int unsigned EXT_H    = 16'h0008;
    localparam int unsigned EN_H     = 16'h0008;
    localparam int unsigned FILT_S   = 16'h0003;
    localparam int unsigned FSHORT_MS = 16'h0064;

    // The same times in milliseconds
    localparam msc_ms_t CONC_CNT   = msc_ms_t'(CONC_S * MS_S);
    localparam msc_ms_t TAIL_CNT   = msc_ms_t'(TAIL_S * MS_S);
    localparam msc_ms_t SEQ_CNT    = msc_ms_t'(SEQ_H * S_H * MS_S);
    localparam msc_ms_t STD_CNT    = msc_ms_t'(STD_MIN * S_MIN * MS_S);
    localparam msc_ms_t LONG_CNT   = msc_ms_t'(LONG_H * S_H * MS_S);
    localparam msc_ms_t EXT_CNT    = msc_ms_t'(EXT_H * S_H * MS_S);
    localparam msc_ms_t EN_CNT     = msc_ms_t'(EN_H * S_H * MS_S);
    localparam msc_ms_t FILT_CNT   = msc_ms_t'(FILT_S * MS_S);
    localparam msc_ms_t FSHORT_CNT = msc_ms_t'(FSHORT_MS);

    // Register map (byte addresses) and fields
    localparam int AW = 4;
    localparam logic [AW-1:0] REG_CTRL = 4'h0;
    localparam logic [AW-1:0] REG_STAT = 4'h4;
    localparam logic [AW-1:0] REG_TIME = 4'h8;
    localparam int C_MODE  = 4'h0;
    localparam int MODE_W  = 4'h3;
    localparam int C_FOUR  = 4'h3;
    localparam int C_T2    = 4'h4;
    localparam int S_STATE = 4'h0;
    localparam int S_OUT   = 4'h6;
    localparam int S_FLT   = 4'h7;
    localparam int S_ENA   = 4'h8;
    localparam int S_EXT   = 4'h9;
    localparam logic [MODE_W-1:0] MODE_RST = 3'h1;

    // Operating mode sets, bit n stands for mode n
    localparam logic [7:0] MSK_VALID = 8'h7e;
    localparam logic [7:0] MSK_SEQ   = 8'h18;
    localparam logic [7:0] MSK_LONG  = 8'h14;
    localparam logic [7:0] MSK_EXT   = 8'h62;
    localparam logic [7:0] MSK_ALT   = 8'h5c;
    localparam logic [7:0] MSK_EN    = 8'h20;
    localparam logic [7:0] MSK_PART  = 8'h40;

    // Input pin positions
    localparam int NPIN  = 4'h9;
    localparam int P_ALT = 4'h4;
    localparam int P_EOT = 4'h5;
    localparam int P_FLD = 4'h6;
    localparam int P_TOP = 4'h7;
    localparam int P_RST = 4'h8;

    // Opening patterns of the four sensor sequence
    localparam logic [3:0] SNR_FWD = 4'h1;
    localparam logic [3:0] SNR_REV = 4'h8;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ARM  = 6'h02,
        ST_MUTE = 6'h04,
        ST_TAIL = 6'h08,
        ST_OVR  = 6'h10,
        ST_FLT  = 6'h20
    } msc_state_t;

endpackage : msc_pkg

// file: src/msc_muting_ctrl.sv
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module msc_muting_ctrl
    import msc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    input  wire logic          clk_i,
    input  wire logic          srst_i,
    input  wire logic [AW-1:0] avs_address_i,
    input  wire logic          avs_read_i,
    input  wire logic          avs_write_i,
    input  wire logic [31:0]   avs_writedata_i,
    input  wire logic [3:0]    avs_byteenable_i,
    output logic [31:0]        avs_readdata_o,
    output logic               avs_waitrequest_o,
    input  wire logic          muting_sensor_first_i,
    input  wire logic          muting_sensor_second_i,
    input  wire logic          muting_sensor_third_i,
    input  wire logic          muting_sensor_fourth_i,
    input  wire logic          muting_sensor_second_alt_i,
    input  wire logic          enable_or_timeout_input_i,
    input  wire logic          field_clear_i,
    input  wire logic          top_beam_clear_i,
    input  wire logic          restart_button_i,
    output logic               safety_switch_output_o,
    output logic               muting_active_o,
    output logic               fault_o
);

    typedef struct packed {
        msc_state_t         st;
        logic [MODE_W-1:0]  mode;
        logic               four;
        logic               t2;
        logic               ack;
        logic [31:0]        rdata;
        logic [NPIN-1:0]    sy1;
        logic [NPIN-1:0]    sy2;
        logic [NPIN-1:0]    sy3;
        logic [NPIN-1:0]    pin;
        logic [31:0]        pre;
        msc_ms_t            tmr;
        msc_ms_t            mute_ms;
        msc_ms_t            win_ms;
        msc_ms_t            en_ms;
        logic               rev;
        logic               seen3;
        logic               ext_ok;
        logic               ext_act;
        logic               ext_done;
        logic               en_arm;
        logic               rst_prev;
        logic               out;
    } msc_regs_t;

    localparam logic [NPIN-1:0] PIN_RST = {{(NPIN-1){1'b0}}, 1'b1} << P_EOT;

    // Enable pin stages start high, so reset alone cannot arm the enable
    localparam msc_regs_t REGS_RST = '{st: ST_IDLE, mode: MODE_RST, sy1: PIN_RST, sy2: PIN_RST,
                                      sy3: PIN_RST, pin: PIN_RST, default: '0};

    msc_regs_t       regs_ff;
    msc_regs_t       nxt_regs;
    logic [NPIN-1:0] pins_raw;
    logic [3:0]      snr;
    logic [3:0]      ord;
    logic [31:0]     rd_word;
    logic            a_s;
    logic            b_s;
    logic            m_seq;
    logic            m_long;
    logic            m_ext;
    logic            m_alt;
    logic            m_en;
    logic            m_part;
    logic            four4;
    logic            muting;
    logic            tick;
    logic            rst_p;
    logic            eot;
    logic            en_ok;
    logic            en_flt;
    logic            to_flt;
    logic            top_flt;
    logic            glob_flt;
    logic            ext_go;
    logic            req;
    msc_ms_t         lim;
    msc_ms_t         filt;

    // Membership of a mode in a set of modes
    function automatic logic mode_in(input logic [MODE_W-1:0] m,
                                     input logic [7:0] set);
        return set[m];
    endfunction : mode_in

    // Saturating millisecond increment
    function automatic msc_ms_t inc_ms(input msc_ms_t v);
        return (&v) ? v : v + 1'b1;
    endfunction : inc_ms

    // Sensors in passing order, first sensor of the pass at bit 0
    function automatic logic [3:0] in_order(input logic [3:0] s,
                                            input logic r);
        return r ? {s[0], s[1], s[2], s[3]} : s;
    endfunction : in_order

    // Raw pins, bit order as the pin positions
    assign pins_raw = {restart_button_i, top_beam_clear_i, field_clear_i,
                       enable_or_timeout_input_i, muting_sensor_second_alt_i,
                       muting_sensor_fourth_i, muting_sensor_third_i,
                       muting_sensor_second_i, muting_sensor_first_i};

    // Mode decode
    assign m_seq  = mode_in(regs_ff.mode, MSK_SEQ);
    assign m_long = mode_in(regs_ff.mode, MSK_LONG);
    assign m_ext  = mode_in(regs_ff.mode, MSK_EXT);
    assign m_alt  = mode_in(regs_ff.mode, MSK_ALT);
    assign m_en   = mode_in(regs_ff.mode, MSK_EN);
    assign m_part = mode_in(regs_ff.mode, MSK_PART);
    assign four4  = regs_ff.four & ~regs_ff.t2 & ~m_seq;

    // Second signal may come from either interface
    assign snr = {regs_ff.pin[3:2],
                  regs_ff.pin[1] | (m_alt & regs_ff.pin[P_ALT]),
                  regs_ff.pin[0]};
    assign ord = in_order(snr, regs_ff.rev);
    assign a_s = snr[0];
    assign b_s = snr[1];

    // Status and timing terms
    assign muting = (regs_ff.st == ST_MUTE) || (regs_ff.st == ST_TAIL)
                 || (regs_ff.st == ST_OVR);
    assign tick   = (regs_ff.pre == 32'(TICK_CYCLES - 1));
    assign rst_p  = regs_ff.pin[P_RST] & ~regs_ff.rst_prev;
    assign eot    = regs_ff.pin[P_EOT];
    assign en_ok  = ~m_en | (regs_ff.en_arm & eot);
    assign en_flt = m_en & (regs_ff.en_ms >= EN_CNT);
    assign lim    = m_long ? LONG_CNT : STD_CNT;
    assign filt   = (regs_ff.four & regs_ff.t2) ? FSHORT_CNT : FILT_CNT;
    assign to_flt = muting & (regs_ff.win_ms >= lim);
    assign top_flt = muting & m_part & ~regs_ff.pin[P_TOP];
    assign glob_flt = to_flt | top_flt | en_flt;
    assign ext_go = m_ext & regs_ff.ext_ok & ~regs_ff.ext_done & ~eot
                  & (regs_ff.mute_ms < EXT_CNT);
    assign req    = avs_read_i | avs_write_i;

    // Register read multiplexer
    always_comb begin
        rd_word = '0;
        if (avs_address_i == REG_CTRL) begin
            rd_word[C_MODE +: MODE_W] = regs_ff.mode;
            rd_word[C_FOUR]           = regs_ff.four;
            rd_word[C_T2]             = regs_ff.t2;
        end else if (avs_address_i == REG_STAT) begin
            rd_word[S_STATE +: 6] = regs_ff.st;
            rd_word[S_OUT]        = regs_ff.out;
            rd_word[S_FLT]        = (regs_ff.st == ST_FLT);
            rd_word[S_ENA]        = regs_ff.en_arm;
            rd_word[S_EXT]        = regs_ff.ext_act;
        end else if (avs_address_i == REG_TIME) begin
            rd_word[TW-1:0] = regs_ff.mute_ms;
        end
    end

    // Next state of the whole block
    always_comb begin
        nxt_regs = regs_ff;
        // Three stage pin synchroniser, change taken when the second and third stages agree
        nxt_regs.sy1 = pins_raw;
        nxt_regs.sy2 = regs_ff.sy1;
        nxt_regs.sy3 = regs_ff.sy2;
        nxt_regs.pin = (regs_ff.sy2 & regs_ff.sy3)
                     | (regs_ff.pin & (regs_ff.sy2 | regs_ff.sy3));
        nxt_regs.rst_prev = regs_ff.pin[P_RST];
        nxt_regs.pre = tick ? '0 : regs_ff.pre + 32'h0000_0001;

        // Bus slave: one wait cycle, then answer
        nxt_regs.ack = req & ~regs_ff.ack;
        if (avs_read_i & ~regs_ff.ack) begin
            nxt_regs.rdata = rd_word;
        end
        if (avs_write_i & regs_ff.ack & avs_byteenable_i[0]
            & (avs_address_i == REG_CTRL)
            & mode_in(avs_writedata_i[C_MODE +: MODE_W], MSK_VALID)) begin
            nxt_regs.mode = avs_writedata_i[C_MODE +: MODE_W];
            nxt_regs.four = avs_writedata_i[C_FOUR];
            nxt_regs.t2   = avs_writedata_i[C_T2];
        end

        // Enable input: armed by a low level, high time measured
        if (~eot) begin
            nxt_regs.en_arm = 1'b1;
            nxt_regs.en_ms  = '0;
        end else if (m_en & tick) begin
            nxt_regs.en_ms = inc_ms(regs_ff.en_ms);
        end

        // Muting duration and timeout window
        if (muting & tick) begin
            nxt_regs.mute_ms = inc_ms(regs_ff.mute_ms);
            if (~ext_go) begin
                nxt_regs.win_ms = inc_ms(regs_ff.win_ms);
            end
        end
        nxt_regs.ext_act = muting & ext_go;
        if (regs_ff.ext_act & ~ext_go) begin
            nxt_regs.ext_done = 1'b1;
            nxt_regs.win_ms   = '0;
        end

        // Muting sequencer
        unique case (regs_ff.st)
            ST_IDLE: begin
                nxt_regs.seen3 = 1'b0;
                if (four4) begin
                    if (snr == SNR_FWD) begin
                        nxt_regs.rev = 1'b0;
                        nxt_regs.st  = ST_ARM;
                    end else if (snr == SNR_REV) begin
                        nxt_regs.rev = 1'b1;
                        nxt_regs.st  = ST_ARM;
                    end
                end else if (m_seq ? (a_s & ~b_s) : (a_s ^ b_s)) begin
                    nxt_regs.st = ST_ARM;
                end
            end
            ST_ARM: begin
                if (tick) begin
                    nxt_regs.tmr = inc_ms(regs_ff.tmr);
                end
                if (four4) begin
                    if (~ord[0] | ord[2] | ord[3]
                        | (regs_ff.tmr >= CONC_CNT)) begin
                        nxt_regs.st = ST_FLT;
                    end else if (ord[1]) begin
                        nxt_regs.st = en_ok ? ST_MUTE : ST_IDLE;
                    end
                end else if (~a_s & ~b_s) begin
                    nxt_regs.st = ST_IDLE;
                end else if (b_s & (a_s | m_seq)) begin
                    nxt_regs.st = en_ok ? ST_MUTE : ST_IDLE;
                end else if (regs_ff.tmr >= (m_seq ? SEQ_CNT : CONC_CNT)) begin
                    nxt_regs.st = ST_FLT;
                end
            end
            ST_MUTE: begin
                nxt_regs.seen3 = regs_ff.seen3 | ord[2];
                if (four4) begin
                    if (~regs_ff.seen3 & (~ord[0] | ~ord[1])) begin
                        nxt_regs.st = ST_FLT;
                    end else if (regs_ff.seen3 & ord[0] & ~ord[1]) begin
                        nxt_regs.st = ST_FLT;
                    end else if (regs_ff.seen3 & ~ord[2]) begin
                        nxt_regs.st = ST_IDLE;
                    end
                end else if (m_seq) begin
                    if (~a_s & ~b_s) begin
                        nxt_regs.st = ST_TAIL;
                    end
                end else if (~a_s & ~b_s) begin
                    nxt_regs.st = ST_IDLE;
                end else if (a_s ^ b_s) begin
                    if (tick) begin
                        nxt_regs.tmr = inc_ms(regs_ff.tmr);
                    end
                    if (regs_ff.tmr >= filt) begin
                        nxt_regs.st = ST_IDLE;
                    end
                end else begin
                    nxt_regs.tmr = '0;
                end
            end
            ST_TAIL: begin
                if (a_s | b_s) begin
                    nxt_regs.st = ST_MUTE;
                end else if (regs_ff.tmr >= TAIL_CNT) begin
                    nxt_regs.st = ST_IDLE;
                end else if (tick) begin
                    nxt_regs.tmr = inc_ms(regs_ff.tmr);
                end
            end
            ST_OVR: begin
                if (snr == '0) begin
                    nxt_regs.st = ST_IDLE;
                end
            end
            ST_FLT: begin
                if (rst_p) begin
                    nxt_regs.st = (|snr) ? ST_OVR : ST_IDLE;
                end
            end
        endcase

        // Faults common to all states; the timeout and top beam faults arise only while muting
        if (glob_flt) begin
            nxt_regs.st = ST_FLT;
        end
        if (nxt_regs.st != regs_ff.st) begin
            nxt_regs.tmr = '0;
        end
        // Fresh timers on every start of muting
        if (~muting & ((nxt_regs.st == ST_MUTE) || (nxt_regs.st == ST_OVR))) begin
            nxt_regs.mute_ms  = '0;
            nxt_regs.win_ms   = '0;
            nxt_regs.ext_done = 1'b0;
            nxt_regs.ext_act  = 1'b0;
            nxt_regs.ext_ok   = eot;
        end
        // Outputs on with clear field and top beam, or muted with top beam rule
        nxt_regs.out = (regs_ff.st != ST_FLT)
                     & ((regs_ff.pin[P_FLD] & regs_ff.pin[P_TOP])
                     | (muting & (regs_ff.pin[P_TOP] | ~m_part)));
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            regs_ff <= REGS_RST;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    // Outputs
    assign avs_waitrequest_o      = req & ~regs_ff.ack;
    assign avs_readdata_o         = regs_ff.rdata;
    assign safety_switch_output_o = regs_ff.out;
    assign muting_active_o        = muting;
    assign fault_o                = (regs_ff.st == ST_FLT);

    // Checks
    mute_out_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (regs_ff.st == ST_MUTE) && !m_part |=> safety_switch_output_o
    ) else $error("outputs off while muted");

    conc_lost_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (regs_ff.st == ST_ARM) && !four4 && !m_seq && (a_s ^ b_s)
        && (regs_ff.tmr >= CONC_CNT) |=> fault_o
    ) else $error("late second sensor not faulted");

    tail_end_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (regs_ff.st == ST_TAIL) && !a_s && !b_s && !glob_flt
        && (regs_ff.tmr >= TAIL_CNT) |=> (regs_ff.st == ST_IDLE)
    ) else $error("clear delay did not end muting");

    seq_limit_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (regs_ff.st == ST_ARM) && m_seq && a_s && !b_s
        && (regs_ff.tmr >= SEQ_CNT) |=> fault_o
    ) else $error("sequence wait not limited");

    order_four_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (regs_ff.st == ST_IDLE) && four4 && (snr != SNR_FWD)
        && (snr != SNR_REV) |=> !muting_active_o && (regs_ff.st != ST_ARM)
    ) else $error("four sensor start out of order");

    four_conc_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (regs_ff.st == ST_ARM) && four4 && (regs_ff.tmr >= CONC_CNT)
        |=> fault_o ##1 !safety_switch_output_o
    ) else $error("four sensor concurrency not faulted");

    four_good_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (regs_ff.st == ST_MUTE) && four4 && regs_ff.seen3 && !ord[2]
        && !(ord[0] && !ord[1]) && !glob_flt && !m_part
        |=> (regs_ff.st == ST_IDLE) && safety_switch_output_o
    ) else $error("third sensor clearing mishandled");

    four_drop_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (regs_ff.st == ST_MUTE) && four4 && !regs_ff.seen3 && !ord[1]
        |=> fault_o
    ) else $error("early sensor dropout not faulted");

    mute_limit_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        muting && (regs_ff.win_ms >= lim) |=> fault_o
    ) else $error("muting timeout not enforced");

    en_refuse_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        !muting && m_en && !en_ok |=> (regs_ff.st != ST_MUTE)
    ) else $error("muting started without enable");

    en_long_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        m_en && eot && (regs_ff.en_ms >= EN_CNT) |=> fault_o
    ) else $error("long enable not faulted");

    top_beam_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        muting && m_part && !regs_ff.pin[P_TOP]
        |=> fault_o && !safety_switch_output_o
    ) else $error("top beam break ignored in mode 6");

    flt_hold_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        fault_o && !rst_p |=> fault_o && !safety_switch_output_o
    ) else $error("fault released without restart");

endmodule : msc_muting_ctrl

`default_nettype wire

// file: test/msc_partner.sv
`timescale 1ns/10ps
`default_nettype none

module msc_partner (
    input  wire logic       clk_i,
    input  wire logic [3:0] pat_i,
    input  wire logic       press_i,
    output logic [3:0]      sensor_o,
    output logic            button_o
);
    // Sensors and button move only just after a clock edge
    always_ff @(posedge clk_i) begin
        sensor_o <= pat_i;
        button_o <= press_i;
    end
endmodule : msc_partner

`default_nettype wire

// file: test/msc_muting_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none

module msc_muting_ctrl_tb;
    import msc_pkg::*;
    localparam int TK = 2;
    logic          clk_i  = 1'b0;
    logic          srst_i = 1'b1;
    logic [AW-1:0] adr    = '0;
    logic          rd     = 1'b0;
    logic          wr     = 1'b0;
    logic [31:0]   wdat   = '0;
    logic [31:0]   rdat;
    logic          wt;
    logic [3:0]    pat    = '0;
    logic [3:0]    sns;
    logic          alt    = 1'b0;
    logic          eot    = 1'b1;
    logic          fld    = 1'b1;
    logic          top    = 1'b1;
    logic          prs    = 1'b0;
    logic          btn, sso, mact, flt;
    logic [31:0]   exp_q[$];
    int            fail_count = 0;
    int            samples_checked = 0;
    int            cyc = 0;

    // Clock and hang guard
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            wrap_up();
        end
    end

    msc_partner part_u (.clk_i(clk_i), .pat_i(pat), .press_i(prs), .sensor_o(sns), .button_o(btn));

    msc_muting_ctrl #(.TICK_CYCLES(TK)) dut_u (
        .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
        .muting_sensor_first_i(sns[0]), .muting_sensor_second_i(sns[1]),
        .muting_sensor_third_i(sns[2]), .muting_sensor_fourth_i(sns[3]),
        .muting_sensor_second_alt_i(alt), .enable_or_timeout_input_i(eot),
        .field_clear_i(fld), .top_beam_clear_i(top), .restart_button_i(btn),
        .safety_switch_output_o(sso), .muting_active_o(mact), .fault_o(flt));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic wrap_up();
        $display("checked=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // One Avalon access; a read notes its expected data
    task automatic bus(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
        if (!w) exp_q.push_back(d);
        adr <= a;
        wdat <= d;
        rd <= ~w;
        wr <= w;
        do begin
            @(posedge clk_i);
        end while (wt !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    // Read data compared at the edge that ends the read
    always @(posedge clk_i) begin
        if (rd && wt === 1'b0) check(rdat, exp_q.pop_front());
    end

    // Restart button press and release
    task automatic press();
        prs <= 1'b1;
        tk(20);
        prs <= 1'b0;
        tk(20);
    endtask : press

    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tk

    task automatic step(input logic [3:0] p);
        pat <= p;
        tk(20);
    endtask : step

    initial begin
        void'($urandom(32'hd526));
        tk(12);
        srst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b1, REG_CTRL, {$urandom() & 32'hffff_ff00} | 32'h0000_0003);
        bus(1'b1, REG_CTRL, 32'h0000_0007);
        bus(1'b1, 4'hc, 32'hffff_ffff);
        bus(0, REG_CTRL, 32'h0000_0003);
        bus(0, 4'hc, 32'h0000_0000);
        // Sequence muting, second signal on the local input
        step(4'h1);
        alt <= 1'b1;
        tk(20);
        fld <= 1'b0;
        tk(20);
        check(sso, 1'b1);
        check(mact, 1'b1);
        step(4'h0);
        alt <= 1'b0;
        tk(4900 * TK);
        check(mact, 1'b1);
        tk(200 * TK);
        check(mact, 1'b0);
        check(sso, 1'b0);
        fld <= 1'b1;
        // Four sensors, mode 1
        bus(1'b1, REG_CTRL, 32'h0000_0009);
        step(4'h2);
        check(mact, 1'b0);
        step(4'h0);
        step(4'h1);
        tk(4100 * TK);
        check(flt, 1'b1);
        check(sso, 1'b0);
        bus(0, REG_STAT, 32'h0000_00a0);
        step(4'h0);
        check(flt, 1'b1);
        prs <= 1'b1;
        tk(20);
        prs <= 1'b0;
        tk(20);
        check(flt, 1'b0);
        step(4'h1);
        step(4'h3);
        step(4'h2);
        check(flt, 1'b1);
        // Restart with a sensor still active overrides the muting path
        fld <= 1'b0;
        press();
        check(mact, 1'b1);
        check(sso, 1'b1);
        step(4'h0);
        prs <= 1'b1;
        tk(20);
        prs <= 1'b0;
        step(4'h1);
        step(4'h3);
        step(4'h7);
        fld <= 1'b0;
        step(4'hf);
        step(4'he);
        step(4'hc);
        check(sso, 1'b1);
        step(4'h8);
        check(mact, 1'b0);
        check(flt, 1'b0);
        // Mode 6 timing two-sensor: partial muting and concurrency limit
        bus(1'b1, REG_CTRL, 32'h0000_0006);
        fld <= 1'b1;
        step(4'h0);
        step(4'h1);
        step(4'h3);
        fld <= 1'b0;
        tk(20);
        check(sso, 1'b1);
        top <= 1'b0;
        tk(20);
        check(flt, 1'b1);
        check(sso, 1'b0);
        top <= 1'b1;
        fld <= 1'b1;
        step(4'h0);
        press();
        step(4'h1);
        tk(4100 * TK);
        check(flt, 1'b1);
        step(4'h0);
        press();
        check(flt, 1'b0);
        // Mode 5: enable honoured only after it was seen low
        bus(1'b1, REG_CTRL, 32'h0000_0005);
        step(4'h1);
        step(4'h3);
        check(mact, 1'b0);
        step(4'h0);
        eot <= 1'b0;
        tk(20);
        eot <= 1'b1;
        step(4'h1);
        step(4'h3);
        check(mact, 1'b1);
        step(4'h0);
        eot <= 1'b0;
        step(4'h1);
        step(4'h3);
        check(mact, 1'b0);
        eot <= 1'b1;
        step(4'h0);
        // Mode 1 two-sensor: extension while the input is low
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        step(4'h1);
        step(4'h3);
        eot <= 1'b0;
        tk(20);
        bus(0, REG_STAT, 32'h0000_0344);
        eot <= 1'b1;
        tk(20);
        bus(0, REG_STAT, 32'h0000_0144);
        step(4'h0);
        // Four-sensor variant with timing two-sensor and short filter
        bus(1'b1, REG_CTRL, 32'h0000_0019);
        step(4'h1);
        step(4'h3);
        pat <= 4'h1;
        tk(50 * TK);
        check(mact, 1'b1);
        tk(100 * TK);
        check(mact, 1'b0);
        step(4'h0);
        wrap_up();
    end
endmodule : msc_muting_ctrl_tb

`default_nettype wire
